// ---- hw/vsr_pkg.sv ----
// Package with constants and carrier types for the valley-skip frequency reducer.
package vsr_pkg;

    localparam int unsigned CLK_FREQ_HZ = 200000000;
    localparam int unsigned EVAL_PERIOD_MS = 48;
    localparam int unsigned EVAL_PERIOD_CYCLES = EVAL_PERIOD_MS * (CLK_FREQ_HZ / 1000);
    localparam int unsigned SOFT_START_MS = 12;
    localparam int unsigned SOFT_START_STEPS = 4;
    localparam int unsigned SOFT_STEP_CYCLES =
        SOFT_START_MS * (CLK_FREQ_HZ / 1000) / SOFT_START_STEPS;
    localparam int unsigned RING_LONG_NS = 5000;
    localparam int unsigned RING_LONG_CYCLES = RING_LONG_NS / 5;
    localparam int unsigned RING_SHORT_NS = 2500;
    localparam int unsigned RING_SHORT_CYCLES = RING_SHORT_NS / 5;
    localparam int unsigned MAX_OFF_NS = 50000;
    localparam int unsigned MAX_OFF_CYCLES = MAX_OFF_NS / 5;

    localparam logic [2:0] SKIP_MIN = 3'h1;
    localparam logic [2:0] SKIP_MAX = 3'h7;
    localparam logic [2:0] SKIP_RESET = 3'h1;
    localparam logic [2:0] VALLEY_MAX = 3'h7;
    localparam logic [1:0] SOFT_STEP_LAST = 2'h3;
    localparam int unsigned CNT_W = 32;

    // Unsynchronised comparator flags coming from the analog front end; the block synchronises them.
    typedef struct packed {
        logic valley_sense;
        logic ring_level_high;
        logic output_overvoltage;
        logic above_count_up;
        logic above_count_down;
        logic above_counter_reset;
        logic peak_reached;
        logic winding_short;
    } vsr_comp_t;

    // Latched protection events.
    typedef struct packed {
        logic overvoltage;
        logic short_winding;
    } vsr_fault_t;

endpackage

// ---- hw/vsr_valley_skip_frequency_reducer.sv ----
// Valley-skip frequency reducer with digital soft-start and switch timing.
//
// Contract
// R1: Soft-start begins when operation starts.
// R2: Soft-start lasts 12ms in 4 steps.
// R3: Peak limit rises from 0.32V to 1V.
// R4: Turn-on digital, turn-off from analog comparison.
// R5: Skip counter holds valleys skipped before turn-on.
// R6: Evaluate feedback each 48ms, update at end.
// R7: Always below low threshold: increment, saturate 7.
// R8: Above low, never above high: hold.
// R9: Above high, never reset threshold: decrement.
// R10: Above reset threshold: force counter to 1.
// R11: Counter stays within 1 to 7.
// R12: Counter starts at 1.
// R13: Thresholds selected by line voltage level.
// R14: Ringing suppression blocks false turn-on.
// R15: Overvoltage from valley input versus threshold.
// R16: Shorted winding checked only while switch on.
// R17: Valley count 0..7, counts falls, clears on-edge.
// R18: After suppression, turn on when count reaches skip.
// R19: No turn-on during ringing suppression.
// R20: Max off interval forces turn-on.
// R21: Comparators synchronised; period flags cleared each period.
// R22: Soft-start step index 0..3 per quarter.
`timescale 1ns/1ps

module vsr_valley_skip_frequency_reducer
    import vsr_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic operation_start_in,
    input wire logic high_line_in,
    input wire vsr_comp_t comp_in,
    output logic gate_drive_out,
    output logic [1:0] soft_step_out,
    output logic soft_start_done_out,
    output logic [2:0] skip_count_out,
    output logic [2:0] valley_count_out,
    output logic high_line_select_out,
    output vsr_fault_t fault_out,
    output logic latched_off_out
);

    typedef enum logic [1:0] {
        VSR_IDLE,
        VSR_ON,
        VSR_RING,
        VSR_WAIT
    } vsr_state_t;

    vsr_comp_t sync1_reg;
    vsr_comp_t sync2_reg;
    vsr_comp_t sync3_reg;
    vsr_state_t state_reg;
    logic running_reg;
    logic [CNT_W-1:0] eval_cnt_reg;
    logic [CNT_W-1:0] soft_cnt_reg;
    logic [CNT_W-1:0] ring_cnt_reg;
    logic [CNT_W-1:0] off_cnt_reg;
    logic [1:0] soft_step_reg;
    logic soft_done_reg;
    logic [2:0] skip_reg;
    logic [2:0] valley_reg;
    logic seen_low_reg;
    logic seen_high_reg;
    logic seen_reset_reg;
    logic high_line_reg;
    vsr_fault_t fault_reg;
    logic eval_end;
    logic valley_fall;
    logic turn_on;
    logic turn_off;
    logic [2:0] skip_next;
    logic gate_reg;
    logic gate_next;
    logic fault_any;
    logic latched_off_reg;

    // Two-stage synchroniser, plus a third stage for edge detection.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
        end else begin
            sync1_reg <= comp_in; // R21
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // Operation runs from the first start request until a protection latch trips.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            running_reg <= 1'b0;
        end else if (operation_start_in && !fault_any) begin
            running_reg <= 1'b1;
        end else if (fault_any) begin
            running_reg <= 1'b0;
        end
    end

    // Soft-start sequencer.
    // The step index selects the current-sense limit; the top step is the final level.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            soft_cnt_reg <= '0;
            soft_step_reg <= 2'h0;
            soft_done_reg <= 1'b0;
        end else if (running_reg && !soft_done_reg) begin // R1
            if (soft_cnt_reg == CNT_W'(SOFT_STEP_CYCLES - 1)) begin // R2
                soft_cnt_reg <= '0;
                if (soft_step_reg == SOFT_STEP_LAST) begin
                    soft_done_reg <= 1'b1;
                end else begin
                    soft_step_reg <= soft_step_reg + 2'h1; // R22 R3
                end
            end else begin
                soft_cnt_reg <= soft_cnt_reg + CNT_W'(1);
            end
        end
    end

    // Evaluation period timer.
    assign eval_end = running_reg && (eval_cnt_reg == CNT_W'(EVAL_PERIOD_CYCLES - 1)); // R6

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            eval_cnt_reg <= '0;
        end else if (!running_reg || eval_end) begin
            eval_cnt_reg <= '0;
        end else begin
            eval_cnt_reg <= eval_cnt_reg + CNT_W'(1);
        end
    end

    // Line-level threshold selection is held for a whole period.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            high_line_reg <= 1'b0;
        end else if (!running_reg || eval_end) begin
            high_line_reg <= high_line_in; // R13
        end
    end

    // Per-period threshold flags; the current sample is folded in at the period end.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            seen_low_reg <= 1'b0;
            seen_high_reg <= 1'b0;
            seen_reset_reg <= 1'b0;
        end else if (!running_reg || eval_end) begin
            seen_low_reg <= 1'b0; // R21
            seen_high_reg <= 1'b0;
            seen_reset_reg <= 1'b0;
        end else begin
            seen_low_reg <= seen_low_reg | sync2_reg.above_count_up;
            seen_high_reg <= seen_high_reg | sync2_reg.above_count_down;
            seen_reset_reg <= seen_reset_reg | sync2_reg.above_counter_reset;
        end
    end

    // Period verdict: the strongest threshold seen decides; saturation keeps 1 to 7.
    always_comb begin
        skip_next = skip_reg;
        if (seen_reset_reg || sync2_reg.above_counter_reset) begin
            skip_next = SKIP_RESET; // R10
        end else if (seen_high_reg || sync2_reg.above_count_down) begin
            if (skip_reg > SKIP_MIN) begin // R11
                skip_next = skip_reg - 3'h1; // R9
            end
        end else if (seen_low_reg || sync2_reg.above_count_up) begin
            skip_next = skip_reg; // R8
        end else if (skip_reg < SKIP_MAX) begin // R11
            skip_next = skip_reg + 3'h1; // R7
        end
    end

    // The skip count restarts from one whenever operation stops, for a full-load start.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            skip_reg <= SKIP_RESET; // R12
        end else if (!running_reg) begin
            skip_reg <= SKIP_RESET; // R12
        end else if (eval_end) begin
            skip_reg <= skip_next; // R5
        end
    end

    // Switch timing.
    // A valley is a falling edge seen between the second and third synchroniser stages.
    assign valley_fall = sync3_reg.valley_sense && !sync2_reg.valley_sense;
    assign turn_off = sync2_reg.peak_reached; // R4

    // Turn-on is only considered once ringing suppression has ended.
    always_comb begin
        turn_on = 1'b0;
        if (state_reg == VSR_WAIT) begin
            if (valley_reg >= skip_reg) begin
                turn_on = 1'b1; // R18
            end else if (off_cnt_reg >= CNT_W'(MAX_OFF_CYCLES - 1)) begin
                turn_on = 1'b1; // R20
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= VSR_IDLE;
        end else if (!running_reg) begin
            state_reg <= VSR_IDLE;
        end else begin
            case (state_reg)
                VSR_IDLE: begin
                    state_reg <= VSR_ON;
                end
                VSR_ON: begin
                    if (turn_off) begin
                        state_reg <= VSR_RING;
                    end
                end
                VSR_RING: begin
                    if (ring_cnt_reg == '0) begin // R19 R14
                        state_reg <= VSR_WAIT;
                    end
                end
                VSR_WAIT: begin
                    if (turn_on) begin
                        state_reg <= VSR_ON;
                    end
                end
                default: begin
                    state_reg <= VSR_IDLE;
                end
            endcase
        end
    end

    // Ringing suppression length depends on the valley input level at turn-off.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ring_cnt_reg <= '0;
        end else if (!running_reg) begin
            ring_cnt_reg <= '0;
        end else if (state_reg == VSR_ON && turn_off) begin
            ring_cnt_reg <= sync2_reg.ring_level_high ? CNT_W'(RING_SHORT_CYCLES - 1)
                : CNT_W'(RING_LONG_CYCLES - 1); // R14
        end else if (ring_cnt_reg != '0) begin
            ring_cnt_reg <= ring_cnt_reg - CNT_W'(1);
        end
    end

    // Off-time counter runs from turn-off, so the limit holds even without valleys.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            off_cnt_reg <= '0;
        end else if (state_reg == VSR_ON || state_reg == VSR_IDLE) begin
            off_cnt_reg <= '0;
        end else begin
            off_cnt_reg <= off_cnt_reg + CNT_W'(1); // R20
        end
    end

    // Valley count saturates at its maximum rather than wrapping back to zero.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            valley_reg <= 3'h0;
        end else if (state_reg == VSR_ON || state_reg == VSR_IDLE) begin
            valley_reg <= 3'h0; // R17
        end else if (valley_fall && valley_reg < VALLEY_MAX) begin
            valley_reg <= valley_reg + 3'h1; // R17
        end
    end

    // Protection latches; cleared only by reset.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fault_reg <= '0;
        end else begin
            if (state_reg == VSR_RING || state_reg == VSR_WAIT) begin
                if (sync2_reg.output_overvoltage) begin
                    fault_reg.overvoltage <= 1'b1; // R15
                end
            end
            if (state_reg == VSR_ON && sync2_reg.winding_short) begin
                fault_reg.short_winding <= 1'b1; // R16
            end
        end
    end

    assign fault_any = fault_reg.overvoltage | fault_reg.short_winding;

    // Gate request per state; a stopped or faulted converter keeps the switch off.
    always_comb begin
        gate_next = 1'b0;
        case (state_reg)
            VSR_IDLE: begin
                gate_next = 1'b1; // R1
            end
            VSR_ON: begin
                gate_next = !turn_off; // R4
            end
            VSR_RING: begin
                gate_next = 1'b0; // R19
            end
            VSR_WAIT: begin
                gate_next = turn_on; // R18
            end
            default: begin
                gate_next = 1'b0;
            end
        endcase
        if (!running_reg || fault_any) begin
            gate_next = 1'b0; // R15 R16
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            gate_reg <= 1'b0;
        end else begin
            gate_reg <= gate_next;
        end
    end

    // The latched-off flag trails the fault latches by one cycle; the registered gate falls in that same cycle.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            latched_off_reg <= 1'b0;
        end else begin
            latched_off_reg <= fault_any;
        end
    end

    assign gate_drive_out = gate_reg;
    assign latched_off_out = latched_off_reg;
    assign fault_out = fault_reg;
    assign soft_step_out = soft_step_reg;
    assign soft_start_done_out = soft_done_reg;
    assign skip_count_out = skip_reg;
    assign valley_count_out = valley_reg;
    assign high_line_select_out = high_line_reg;

endmodule // vsr_valley_skip_frequency_reducer

// ---- tb/vsr_chk.sv ----
// Port-level assertions for the valley-skip frequency reducer.
`timescale 1ns/1ps
module vsr_chk
    import vsr_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire vsr_comp_t comp_in,
    input wire logic gate_drive_out,
    input wire logic [1:0] soft_step_out,
    input wire logic soft_start_done_out,
    input wire logic [2:0] skip_count_out,
    input wire logic [2:0] valley_count_out,
    input wire vsr_fault_t fault_out,
    input wire logic latched_off_out
);
    logic [31:0] cyc_reg;
    logic [31:0] off_reg;
    logic seen_reg;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // Cycles since reset, cycles with the switch off, and whether it has switched yet.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cyc_reg <= 32'h0;
            off_reg <= 32'h0;
            seen_reg <= 1'b0;
        end else begin
            cyc_reg <= cyc_reg + 32'h1;
            off_reg <= gate_drive_out ? 32'h0 : off_reg + 32'h1;
            seen_reg <= seen_reg | gate_drive_out;
        end
    end
    property p_range; skip_count_out != 3'h0; endproperty
    a_range: assert property (p_range) else $error("skip count out of range");
    property p_init; cyc_reg < 32'h927C00 |-> skip_count_out == 3'h1; endproperty
    a_init: assert property (p_init) else $error("skip count not one");
    property p_soft; cyc_reg < 32'h927C0 |-> soft_step_out == 2'h0 && !soft_start_done_out;
    endproperty
    a_soft: assert property (p_soft) else $error("soft step early");
    property p_vhold; gate_drive_out && $past(gate_drive_out) |-> valley_count_out == 3'h0;
    endproperty
    a_vhold: assert property (p_vhold) else $error("valley count not cleared");
    property p_ring; $rose(gate_drive_out) && seen_reg |-> off_reg >= 32'h1F3; endproperty
    a_ring: assert property (p_ring) else $error("turn-on inside ringing time");
    property p_maxoff; seen_reg && !latched_off_out |-> off_reg <= 32'h2713; endproperty
    a_maxoff: assert property (p_maxoff) else $error("off time too long");
    property p_off; $rose(comp_in.peak_reached) && gate_drive_out |-> ##3 !gate_drive_out;
    endproperty
    a_off: assert property (p_off) else $error("late turn-off");
    property p_short;
        $rose(fault_out.short_winding) |-> seen_reg && (gate_drive_out || off_reg <= 32'h5);
    endproperty
    a_short: assert property (p_short) else $error("short fault while off");
    property p_latch; latched_off_out |=> latched_off_out ##1 !gate_drive_out; endproperty
    a_latch: assert property (p_latch) else $error("fault not held");
    c_on: cover property ($rose(gate_drive_out) && seen_reg);
    c_fault: cover property ($rose(latched_off_out));
    c_vfull: cover property (valley_count_out == 3'h7);
endmodule // vsr_chk

// ---- tb/vsr_stage_model.sv ----
// Behavioural model of the comparators and power stage around the block.
`timescale 1ns/1ps
module vsr_stage_model
    import vsr_pkg::*;
(
    input wire logic clk_in,
    input wire logic gate_in,
    input wire logic valleys_in,
    input wire logic ring_high_in,
    input wire logic ov_in,
    input wire logic short_in,
    output vsr_comp_t comp_out
);
    int on_cnt;
    int ring_cnt;
    initial begin
        comp_out = '0;
    end
    always @(posedge clk_in) begin
        #1;
        on_cnt = gate_in ? on_cnt + 1 : 0;
        ring_cnt = gate_in ? 0 : ring_cnt + 1;
        comp_out = '0;
        comp_out.peak_reached = on_cnt >= 8;
        comp_out.valley_sense = valleys_in && !gate_in && ring_cnt[4];
        comp_out.ring_level_high = ring_high_in;
        comp_out.output_overvoltage = ov_in;
        comp_out.winding_short = short_in;
    end
endmodule // vsr_stage_model

// ---- tb/test_valley_skip_frequency_reducer.sv ----
// Self-checking testbench for the valley-skip frequency reducer.
`timescale 1ns/1ps
module test_valley_skip_frequency_reducer;
    import vsr_pkg::*;
    logic clk_in;
    logic rst_n_in;
    logic operation_start_in;
    logic valleys;
    logic ring_high;
    logic ov;
    logic short_w;
    logic high_line;
    logic high_line_select_out;
    vsr_comp_t comp_in;
    logic gate_drive_out;
    logic [1:0] soft_step_out;
    logic soft_start_done_out;
    logic [2:0] skip_count_out;
    logic [2:0] valley_count_out;
    vsr_fault_t fault_out;
    logic latched_off_out;
    int n_errors;
    int checked;
    int n;
    logic [2:0] v;
    vsr_valley_skip_frequency_reducer vsr_valley_skip_frequency_reducer_inst (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .operation_start_in(operation_start_in),
        .high_line_in(high_line), .comp_in(comp_in), .gate_drive_out(gate_drive_out),
        .soft_step_out(soft_step_out), .soft_start_done_out(soft_start_done_out),
        .skip_count_out(skip_count_out), .valley_count_out(valley_count_out),
        .high_line_select_out(high_line_select_out), .fault_out(fault_out),
        .latched_off_out(latched_off_out));
    vsr_stage_model vsr_stage_model_inst (.clk_in(clk_in), .gate_in(gate_drive_out),
        .valleys_in(valleys), .ring_high_in(ring_high), .ov_in(ov), .short_in(short_w),
        .comp_out(comp_in));
    task tick;
        @(posedge clk_in);
        #1;
    endtask
    task check(string what, logic [31:0] exp, logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task check_span(string what, int lo, int hi, int got);
        check(what, 32'h1, {31'h0, got >= lo && got <= hi});
    endtask
    task automatic wait_gate(logic lvl);
        for (int k = 0; k < 20000 && gate_drive_out !== lvl; k++) tick;
    endtask
    // Length of one off interval and the valley count just before turn-on.
    task automatic measure_off(output int n, output logic [2:0] v);
        n = 0;
        wait_gate(1'b1);
        wait_gate(1'b0);
        while (gate_drive_out !== 1'b1 && n < 20000) begin
            v = valley_count_out;
            tick;
            n++;
        end
    endtask
    task do_reset;
        rst_n_in = 1'b0;
        operation_start_in = 1'b0;
        repeat (6) tick;
        rst_n_in = 1'b1;
        tick;
    endtask
    task t_reset;
        do_reset;
        check("gate", 32'h0, gate_drive_out);
        check("line", 32'h1, high_line_select_out);
        check("step", 32'h0, {soft_step_out, soft_start_done_out});
        check("skip", 32'h1, skip_count_out);
        check("valley", 32'h0, valley_count_out);
        check("fault", 32'h0, fault_out);
        $display("t_reset done");
    endtask
    task t_rings;
        operation_start_in = 1'b1;
        measure_off(n, v);
        check_span("long ring", 1000, 1006, n);
        check("valley", 32'h7, v);
        ring_high = 1'b1;
        high_line = 1'b0;
        measure_off(n, v);
        check_span("short ring", 500, 506, n);
        ring_high = 1'b0;
        check("line held", 32'h1, high_line_select_out);
        $display("t_rings done");
    endtask
    task t_max_off;
        valleys = 1'b0;
        measure_off(n, v);
        check_span("max off", 9999, 10005, n);
        check("valley", 32'h0, v);
        valleys = 1'b1;
        $display("t_max_off done");
    endtask
    task t_short;
        wait_gate(1'b0);
        short_w = 1'b1;
        repeat (400) tick;
        check("fault off", 32'h0, fault_out);
        for (int k = 0; k < 1500 && latched_off_out !== 1'b1; k++) tick;
        check("fault on", 32'h1, fault_out);
        repeat (50) tick;
        check("gate held", 32'h1, {gate_drive_out, latched_off_out});
        short_w = 1'b0;
        $display("t_short done");
    endtask
    task t_ov;
        do_reset;
        check("fault clr", 32'h0, fault_out);
        check("line low", 32'h0, high_line_select_out);
        operation_start_in = 1'b1;
        wait_gate(1'b1);
        wait_gate(1'b0);
        ov = 1'b1;
        repeat (10) tick;
        check("ov fault", 32'h2, fault_out);
        check("ov gate", 32'h0, gate_drive_out);
        ov = 1'b0;
        $display("t_ov done");
    endtask
    task test_done;
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    initial begin
        #500000;
        n_errors++;
        test_done;
    end
    initial begin
        rst_n_in = 1'b0;
        operation_start_in = 1'b0;
        valleys = 1'b1;
        ring_high = 1'b0;
        high_line = 1'b1;
        ov = 1'b0;
        short_w = 1'b0;
        n_errors = 0;
        checked = 0;
        t_reset;
        t_rings;
        t_max_off;
        t_short;
        t_ov;
        test_done;
    end
endmodule // test_valley_skip_frequency_reducer
bind vsr_valley_skip_frequency_reducer vsr_chk vsr_chk_inst (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .comp_in(comp_in), .gate_drive_out(gate_drive_out),
    .soft_step_out(soft_step_out), .soft_start_done_out(soft_start_done_out),
    .skip_count_out(skip_count_out), .valley_count_out(valley_count_out),
    .fault_out(fault_out), .latched_off_out(latched_off_out));
